// *** inc/hbra_pkg.sv ***
/*
 * Shared constants, region decode and types for the host bus region access block.
 * Assumes a byte-wide host port and a 20-bit byte address.
 */
package hbra_pkg;

    // ****************************************************************
    // Widths and region decode
    // ****************************************************************
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int REG_W = 32;
    localparam int MEM_AW = 16;
    localparam int NIB_LSB = 16;
    localparam logic [3:0] NIB_REG = 4'h0;
    localparam logic [3:0] NIB_VCM = 4'h1;
    localparam logic [3:0] NIB_DM = 4'h2;
    localparam logic [3:0] NIB_CM = 4'h4;

    typedef enum logic [2:0] {RG_REG, RG_VCM, RG_DM, RG_CM, RG_RSVD} hbra_region_e;

    // ****************************************************************
    // Register map, byte addresses of each dword
    // ****************************************************************
    localparam int NUM_REGS = 18;
    localparam int IDX_W = 5;
    localparam logic [ADDR_W-1:0] REG_OFFS [NUM_REGS] = '{
        20'h0_0410, 20'h0_0420, 20'h0_0430, 20'h0_0440, 20'h0_0450, 20'h0_0460,
        20'h0_0470, 20'h0_0474, 20'h0_0480, 20'h0_0500, 20'h0_0600, 20'h0_0604,
        20'h0_0608, 20'h0_060C, 20'h0_0610, 20'h0_0614, 20'h0_06FC, 20'h0_0140};
    localparam logic [IDX_W-1:0] IDX_DIAG = 5'h11;
    localparam int VC_EN_BIT = 0;
    localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RSVD_READ = 8'h00;

    // ****************************************************************
    // Timing, figures in ns and derived cycle counts
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_ACK_MIN_NS = 36;
    localparam int T_RDY_HI_MAX_NS = 72;
    localparam int T_ACK_MAX_NS = 70;
    localparam int ACK_MIN_CYC = (T_ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RDY_MAX_CYC = T_RDY_HI_MAX_NS / CLK_PERIOD_NS;
    localparam int ACK_MAX_CYC = T_ACK_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ACK_MIN_CYC - 1);

    // Region of a host byte address
    function automatic hbra_region_e region_of(input logic [ADDR_W-1:0] a);
        unique case (a[ADDR_W-1:NIB_LSB])
            NIB_REG: region_of = RG_REG;
            NIB_VCM: region_of = RG_VCM;
            NIB_DM: region_of = RG_DM;
            NIB_CM: region_of = RG_CM;
            default: region_of = RG_RSVD;
        endcase
    endfunction

endpackage

// *** inc/hbra_reg_if.sv ***
/*
 * Carrier between the access controller and the register file.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/100ps
interface hbra_reg_if;
    logic [hbra_pkg::ADDR_W-1:0] addr;
    logic [hbra_pkg::DATA_W-1:0] wdata;
    logic we;
    logic [hbra_pkg::DATA_W-1:0] rdata;
    logic vc_en;

    modport ctrl (output addr, output wdata, output we, input rdata, input vc_en);
    modport regs (input addr, input wdata, input we, output rdata, output vc_en);
endinterface

// *** logic/hbra_sync.sv ***
/*
 * Two-stage synchroniser for a group of host strobes.
 * Assumes the inputs may change at any time relative to the clock.
 */
`timescale 1ns/100ps
module hbra_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // First stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end
        else if (ce)
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

// *** logic/hbra_regfile.sv ***
/*
 * Register file of the frame group, pin I/O, interrupt and diagnostic dwords.
 * Assumes byte accesses; the byte lane is the low two address bits.
 */
`timescale 1ns/100ps
module hbra_regfile (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    hbra_reg_if.regs rif
);
    logic [hbra_pkg::REG_W-1:0] regs_ff [hbra_pkg::NUM_REGS];
    logic [hbra_pkg::REG_W-1:0] nxt_regs [hbra_pkg::NUM_REGS];
    logic hit;
    logic [hbra_pkg::IDX_W-1:0] idx;
    logic [1:0] lane;

    // Dword index of an address, with a hit flag in the top bit
    function automatic logic [hbra_pkg::IDX_W:0] index_of(
        input logic [hbra_pkg::ADDR_W-1:0] a);
        index_of = '0;
        for (int i = 0; i < hbra_pkg::NUM_REGS; i++)
        begin
            if ({a[hbra_pkg::ADDR_W-1:2], 2'b00} == hbra_pkg::REG_OFFS[i])
            begin
                index_of = {1'b1, hbra_pkg::IDX_W'(i)};
            end
        end
    endfunction

    // Decode and read; unmapped bytes read as zero
    always_comb
    begin
        {hit, idx} = index_of(rif.addr);
        lane = rif.addr[1:0];
        rif.rdata = hit ? regs_ff[idx][{lane, 3'b000} +: hbra_pkg::DATA_W]
                        : hbra_pkg::RSVD_READ;
    end

    // Byte-lane write
    always_comb
    begin
        nxt_regs = regs_ff;
        if (rif.we && hit)
        begin
            nxt_regs[idx][{lane, 3'b000} +: hbra_pkg::DATA_W] = rif.wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < hbra_pkg::NUM_REGS; i++)
            begin
                regs_ff[i] <= hbra_pkg::REG_RESET;
            end
        end
        else if (ce)
        begin
            regs_ff <= nxt_regs;
        end
    end

    // Diagnostic enable for the virtual channel region, clear after reset
    assign rif.vc_en = regs_ff[hbra_pkg::IDX_DIAG][hbra_pkg::VC_EN_BIT];
endmodule

// *** logic/hbra_top.sv ***
/*
 * Host bus region access controller: strobe sync, region decode, memory
 * arbitration and the ready or acknowledge handshake.
 * Assumes a switching engine outside that owns data, virtual channel and
 * connection memory and flags busy data memory slots.
 */
// Behaviour
// - Decode 20-bit address into four regions
// - Synchronise host strobes before acting
// - Register accesses never stall, fixed latency
// - Reserved register reads return zero
// - Connection memory served at once, dedicated slot
// - Data memory granted only behind switching
// - Data memory acknowledge delay is open-ended
// - Virtual channel access blocked until enabled
// - Enabled virtual channel access lowest priority
// - No virtual connections: answer like registers
// - Ready drops once an access begins
// - Ready returns after fixed register latency
// - Acknowledge asserts after fixed register latency
// - Acknowledge releases soon after strobe ends
// - Frame group, pin and interrupt registers mapped
`timescale 1ns/100ps
module hbra_top #(
    parameter int ADDR_W = hbra_pkg::ADDR_W,
    parameter int DATA_W = hbra_pkg::DATA_W
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic ACK_MODE,
    input wire logic HOST_CS_N,
    input wire logic HOST_RD_N,
    input wire logic HOST_WR_N,
    input wire logic [ADDR_W-1:0] HOST_ADDR,
    input wire logic [DATA_W-1:0] HOST_WDATA,
    output logic [DATA_W-1:0] HOST_RDATA,
    output logic HOST_DATA_OE,
    output logic HOST_READY,
    output logic ACK_MODE_TRANSFER_ACK_N,
    input wire logic VC_CONN_PRESENT,
    input wire logic TDM_MEM_BUSY,
    output logic MEM_REQ,
    output logic MEM_VC_SEL,
    output logic MEM_WE,
    output logic [hbra_pkg::MEM_AW-1:0] MEM_ADDR,
    output logic [DATA_W-1:0] MEM_WDATA,
    input wire logic [DATA_W-1:0] MEM_RDATA,
    output logic CM_REQ,
    output logic CM_WE,
    output logic [hbra_pkg::MEM_AW-1:0] CM_ADDR,
    output logic [DATA_W-1:0] CM_WDATA,
    input wire logic [DATA_W-1:0] CM_RDATA
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (ADDR_W != hbra_pkg::ADDR_W)
    begin : g_chk_addr
        $error("Address width must be 20");
    end
    if (DATA_W != hbra_pkg::DATA_W)
    begin : g_chk_data
        $error("Data width must be 8");
    end
    if (hbra_pkg::ACK_MIN_CYC > hbra_pkg::ACK_MAX_CYC ||
        hbra_pkg::ACK_MIN_CYC > hbra_pkg::RDY_MAX_CYC)
    begin : g_chk_time
        $error("Minimum acknowledge latency exceeds its maximum");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD} hbra_state_e;

    hbra_reg_if rif ();

    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic act;
    logic is_wr;
    logic mem_go;
    logic mem_need;
    hbra_pkg::hbra_region_e reg_eff;

    hbra_state_e st_ff;
    hbra_state_e nxt_st;
    logic [hbra_pkg::CNT_W-1:0] cnt_ff;
    logic [hbra_pkg::CNT_W-1:0] nxt_cnt;
    hbra_pkg::hbra_region_e region_ff;
    hbra_pkg::hbra_region_e nxt_region;
    logic wr_ff;
    logic nxt_wr;
    logic done_ff;
    logic nxt_done;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] nxt_wdata;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    // ****************************************************************
    // Strobe synchronisation and decode
    // ****************************************************************
    hbra_sync #(
        .W(3),
        .RST_VAL(3'b111)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .ce(CE),
        .d({HOST_CS_N, HOST_RD_N, HOST_WR_N}),
        .q({cs_n_s, rd_n_s, wr_n_s})
    );

    // Ready style: separate read and write strobes; acknowledge style:
    // data strobe on the read pin, read-not-write on the write pin
    always_comb
    begin
        if (ACK_MODE)
        begin
            act = !cs_n_s && !rd_n_s;
        end
        else
        begin
            act = !cs_n_s && (!rd_n_s || !wr_n_s);
        end
        is_wr = !wr_n_s;
    end

    // Effective region of the incoming access
    always_comb
    begin
        reg_eff = hbra_pkg::region_of(HOST_ADDR);
        if (reg_eff == hbra_pkg::RG_VCM && !rif.vc_en)
        begin
            reg_eff = hbra_pkg::RG_RSVD;
        end
    end

    // ****************************************************************
    // Memory arbitration, host at lowest priority
    // ****************************************************************
    always_comb
    begin
        mem_need = (region_ff == hbra_pkg::RG_DM) || (region_ff == hbra_pkg::RG_VCM);
        MEM_REQ = (st_ff == ST_WAIT) && mem_need && !done_ff;
        // Switching owns the slot when busy; with no virtual connections
        // the virtual channel memory has no competing traffic
        mem_go = MEM_REQ && (!TDM_MEM_BUSY ||
                 (region_ff == hbra_pkg::RG_VCM && !VC_CONN_PRESENT));
    end

    assign MEM_VC_SEL = (region_ff == hbra_pkg::RG_VCM);
    assign MEM_WE = wr_ff;
    assign MEM_ADDR = addr_ff[hbra_pkg::MEM_AW-1:0];
    assign MEM_WDATA = wdata_ff;

    // Connection memory uses the dedicated host slot in the first cycle
    assign CM_REQ = (st_ff == ST_WAIT) && (cnt_ff == hbra_pkg::CNT_ZERO)
                    && (region_ff == hbra_pkg::RG_CM);
    assign CM_WE = wr_ff;
    assign CM_ADDR = addr_ff[hbra_pkg::MEM_AW-1:0];
    assign CM_WDATA = wdata_ff;

    // Register file port
    assign rif.addr = addr_ff;
    assign rif.wdata = wdata_ff;
    assign rif.we = (st_ff == ST_WAIT) && (cnt_ff == hbra_pkg::CNT_ZERO)
                    && (region_ff == hbra_pkg::RG_REG) && wr_ff;

    hbra_regfile u_regs (
        .clk(CORE_CLK),
        .rst(RST),
        .ce(CE),
        .rif(rif)
    );

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_region = region_ff;
        nxt_wr = wr_ff;
        nxt_done = done_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        unique case (st_ff)
            ST_IDLE:
            begin
                if (act)
                begin
                    nxt_st = ST_WAIT;
                    nxt_cnt = hbra_pkg::CNT_ZERO;
                    nxt_region = reg_eff;
                    nxt_wr = is_wr;
                    nxt_done = 1'b0;
                    nxt_addr = HOST_ADDR;
                    nxt_wdata = HOST_WDATA;
                end
            end
            ST_WAIT:
            begin
                if (cnt_ff != hbra_pkg::CNT_LAST)
                begin
                    nxt_cnt = cnt_ff + hbra_pkg::CNT_ONE;
                end
                if (cnt_ff == hbra_pkg::CNT_ZERO)
                begin
                    unique case (region_ff)
                        hbra_pkg::RG_REG: nxt_rdata = rif.rdata;
                        hbra_pkg::RG_CM: nxt_rdata = CM_RDATA;
                        hbra_pkg::RG_RSVD: nxt_rdata = hbra_pkg::RSVD_READ;
                        default: nxt_rdata = rdata_ff;
                    endcase
                end
                if (mem_go)
                begin
                    nxt_done = 1'b1;
                    nxt_rdata = MEM_RDATA;
                end
                // Fixed latency for immediate regions; memory regions also
                // wait for the transfer, however long switching takes
                if (!act)
                begin
                    nxt_st = ST_IDLE;
                end
                else if (cnt_ff == hbra_pkg::CNT_LAST && (!mem_need || done_ff))
                begin
                    nxt_st = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (!act)
                begin
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            st_ff <= ST_IDLE;
            cnt_ff <= hbra_pkg::CNT_ZERO;
            region_ff <= hbra_pkg::RG_RSVD;
            wr_ff <= 1'b0;
            done_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= '0;
            rdata_ff <= '0;
        end
        else if (CE)
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            region_ff <= nxt_region;
            wr_ff <= nxt_wr;
            done_ff <= nxt_done;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************************************
    // Host handshake outputs
    // ****************************************************************
    // Ready falls as soon as an access is seen and stays low until done
    assign HOST_READY = ACK_MODE ||
                        !((st_ff == ST_IDLE && act) || st_ff == ST_WAIT);
    assign ACK_MODE_TRANSFER_ACK_N = !(ACK_MODE && st_ff == ST_HOLD);
    assign HOST_DATA_OE = (st_ff == ST_HOLD) && !wr_ff;
    assign HOST_RDATA = rdata_ff;

endmodule

// *** test/hbra_asserts.sv ***
/*
 * Concurrent checks on the ports of the host bus region access top.
 * Assumes the host holds every access until it is answered.
 */
`timescale 1ns/100ps
module hbra_asserts (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic ACK_MODE,
    input wire logic HOST_CS_N,
    input wire logic [hbra_pkg::ADDR_W-1:0] HOST_ADDR,
    input wire logic [hbra_pkg::DATA_W-1:0] HOST_WDATA,
    input wire logic HOST_DATA_OE,
    input wire logic HOST_READY,
    input wire logic ACK_MODE_TRANSFER_ACK_N,
    input wire logic VC_CONN_PRESENT,
    input wire logic TDM_MEM_BUSY,
    input wire logic MEM_REQ,
    input wire logic MEM_VC_SEL,
    input wire logic MEM_WE,
    input wire logic [hbra_pkg::DATA_W-1:0] MEM_WDATA,
    input wire logic [hbra_pkg::MEM_AW-1:0] MEM_ADDR,
    input wire logic CM_REQ,
    input wire logic CM_WE,
    input wire logic [hbra_pkg::DATA_W-1:0] CM_WDATA,
    input wire logic [hbra_pkg::MEM_AW-1:0] CM_ADDR
);
    // ****
    // Checks
    // ****
    logic fixed_rg;
    logic ack_n;

    // Regions answered at fixed latency
    assign fixed_rg = HOST_ADDR[19:16] != 4'h1 && HOST_ADDR[19:16] != 4'h2;
    assign ack_n = ACK_MODE_TRANSFER_ACK_N;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // Ready drop, hold and return
    sequence rdy_walk;
        HOST_READY[*2] ##1 !HOST_READY[*5] ##1 HOST_READY;
    endsequence

    // Acknowledge after sync and count
    sequence ack_walk;
        ack_n[*6] ##[1:2] !ack_n;
    endsequence

    AST_RDY_FIXED: assert property ($fell(HOST_CS_N) && !ACK_MODE && fixed_rg |-> rdy_walk)
        else $error("ready timing off");
    AST_ACK_FIXED: assert property ($fell(HOST_CS_N) && ACK_MODE && fixed_rg |-> ack_walk)
        else $error("acknowledge timing off");
    AST_ACK_FLOOR: assert property ($fell(HOST_CS_N) |-> ack_n[*6])
        else $error("answer before strobe sync");
    AST_ACK_RELEASE: assert property ($rose(HOST_CS_N) && !ack_n |-> ##[1:3] ack_n)
        else $error("acknowledge not released");
    AST_MODE_IDLE: assert property (ACK_MODE ? HOST_READY : ack_n)
        else $error("wrong handshake for mode");
    AST_HELD: assert property (MEM_REQ |-> ack_n && (ACK_MODE || !HOST_READY))
        else $error("answered before memory slot");
    AST_MEM_WAIT: assert property (MEM_REQ && TDM_MEM_BUSY && !(MEM_VC_SEL && !VC_CONN_PRESENT)
        |=> MEM_REQ)
        else $error("host won a busy slot");
    AST_MEM_ONCE: assert property (MEM_REQ && !TDM_MEM_BUSY |=> !MEM_REQ)
        else $error("more than one grant");
    AST_VC_FAST: assert property (MEM_REQ && MEM_VC_SEL && !VC_CONN_PRESENT |=> !MEM_REQ)
        else $error("idle virtual channel access waited");
    AST_MEM_ADDR: assert property (MEM_REQ |-> MEM_ADDR == HOST_ADDR[15:0]
        && MEM_VC_SEL == (HOST_ADDR[19:16] == 4'h1))
        else $error("memory request decode wrong");
    AST_CM_ONE: assert property (CM_REQ |-> CM_ADDR == HOST_ADDR[15:0]
        && HOST_ADDR[19:16] == 4'h4 ##1 !CM_REQ)
        else $error("connection memory request wrong");
    AST_WR_DATA: assert property ((MEM_REQ && MEM_WE |-> MEM_WDATA == HOST_WDATA)
        and (CM_REQ && CM_WE |-> CM_WDATA == HOST_WDATA))
        else $error("memory write data wrong");
    AST_OE_ANSWERED: assert property (HOST_DATA_OE |-> (ACK_MODE ? !ack_n : HOST_READY))
        else $error("read data driven before answer");
endmodule

// *** test/hbra_host_model.sv ***
/*
 * Host processor model driving the asynchronous byte bus.
 * Assumes the bench calls access from one process at a time.
 */
`timescale 1ns/100ps
module hbra_host_model (
    input wire logic clk,
    input wire logic ack_mode,
    input wire logic ready,
    input wire logic ack_n,
    input wire logic [7:0] rdata,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [19:0] addr,
    output logic [7:0] wdata
);
    // ****
    // Bus cycles
    // ****
    initial
    begin
        cs_n = 1'h1;
        rd_n = 1'h1;
        wr_n = 1'h1;
        addr = 20'h0_0000;
        wdata = 8'h00;
    end

    // One byte access, held until answered
    task automatic access(input logic w, input logic [19:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic to);
        int n;
        n = 0;
        @(negedge clk);
        cs_n = 1'h0;
        rd_n = ack_mode ? 1'h0 : w; // Data strobe in acknowledge mode
        wr_n = !w;
        addr = a;
        wdata = d;
        do
        begin
            @(negedge clk); // Sample the answer where it has settled
            n++;
        end while (n < 300 && (n < 5 || (ack_mode ? ack_n : !ready)));
        q = rdata;
        to = n >= 300;
        @(negedge clk);
        cs_n = 1'h1;
        rd_n = 1'h1;
        wr_n = 1'h1;
        addr = ~a; // Released lines keep no stale value
        wdata = ~d;
        repeat (4) @(negedge clk);
    endtask
endmodule

// *** test/tb_host_bus_region_access.sv ***
/*
 * Self-checking bench for the host bus region access block.
 * Assumes the host model and checker are compiled before it.
 */
`timescale 1ns/100ps
module tb_host_bus_region_access;
    // ****
    // Bench
    // ****
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic ack_mode = 1'h0;
    logic vc_conn = 1'h0;
    logic busy = 1'h0;
    logic busy_hold = 1'h0;
    logic cs_n, rd_n, wr_n, ready, ack_n;
    logic [19:0] addr, a;
    logic [7:0] wdata, rdata, mem_rdata, cm_rdata, junk;
    logic [15:0] mem_addr, cm_addr;
    logic [15:0] lfsr = 16'hDF16;
    logic [15:0] blfsr = 16'hDF16;
    logic [3:0] rsv [3] = '{4'h3, 4'h5, 4'hF};
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    hbra_top uut (
        .CORE_CLK(core_clk),
        .RST(rst),
        .CE(1'h1),
        .ACK_MODE(ack_mode),
        .HOST_CS_N(cs_n),
        .HOST_RD_N(rd_n),
        .HOST_WR_N(wr_n),
        .HOST_ADDR(addr),
        .HOST_WDATA(wdata),
        .HOST_RDATA(rdata),
        .HOST_DATA_OE(),
        .HOST_READY(ready),
        .ACK_MODE_TRANSFER_ACK_N(ack_n),
        .VC_CONN_PRESENT(vc_conn),
        .TDM_MEM_BUSY(busy),
        .MEM_REQ(),
        .MEM_VC_SEL(),
        .MEM_WE(),
        .MEM_ADDR(mem_addr),
        .MEM_WDATA(),
        .MEM_RDATA(mem_rdata),
        .CM_REQ(),
        .CM_WE(),
        .CM_ADDR(cm_addr),
        .CM_WDATA(),
        .CM_RDATA(cm_rdata)
    );

    hbra_host_model host (.clk(core_clk), .*);

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] mem_fn(input logic [15:0] x);
        mem_fn = x[7:0] ^ x[15:8] ^ 8'hA5;
    endfunction
    function automatic logic [7:0] cm_fn(input logic [15:0] x);
        cm_fn = x[7:0] + 8'h3C;
    endfunction

    // Switching engine side
    assign mem_rdata = mem_fn(mem_addr);
    assign cm_rdata = cm_fn(cm_addr);

    always #5 core_clk = ~core_clk;

    // Random slot usage by switching
    always @(negedge core_clk)
    begin
        blfsr = lfsr_next(blfsr);
        busy <= busy_hold | blfsr[0];
    end

    // Hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [19:0] x, input logic [7:0] d,
                       output logic [7:0] q);
        logic to;
        host.access(w, x, d, q, to);
        if (to)
        begin
            error_cnt++;
            $display("wrong value at %0t: no answer", $time);
        end
    endtask

    task automatic rd(input logic [19:0] x, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'h0, x, 8'h00, q);
        chk(q, exp);
    endtask

    // Main sequence, both handshake styles
    initial
    begin
        repeat (5) @(negedge core_clk);
        rst = 1'h0;
        for (int m = 0; m < 2; m++)
        begin
            ack_mode = m[0];
            acc(1'h1, 20'h0_0140, 8'h00, junk);
            lfsr = lfsr_next(lfsr);
            rd({4'h1, lfsr}, 8'h00);
            for (int i = 0; i < hbra_pkg::NUM_REGS - 1; i++)
            begin
                lfsr = lfsr_next(lfsr);
                a = hbra_pkg::REG_OFFS[i] | 20'(lfsr[1:0]);
                acc(1'h1, a, lfsr[15:8], junk);
                rd(a, lfsr[15:8]);
            end
            acc(1'h1, 20'h0_0700, 8'hFF, junk);
            rd(20'h0_0700, 8'h00);
            foreach (rsv[k])
            begin
                acc(1'h1, {rsv[k], lfsr}, 8'h5A, junk);
                rd({rsv[k], lfsr}, 8'h00);
            end
            repeat (6)
            begin
                lfsr = lfsr_next(lfsr);
                acc(1'h1, {4'h2, lfsr}, lfsr[7:0], junk);
                rd({4'h2, lfsr}, mem_fn(lfsr));
                acc(1'h1, {4'h4, lfsr}, lfsr[7:0], junk);
                rd({4'h4, lfsr}, cm_fn(lfsr));
            end
            busy_hold = 1'h1;
            fork
                rd({4'h2, lfsr}, mem_fn(lfsr));
                begin
                    repeat (30) @(negedge core_clk);
                    busy_hold = 1'h0;
                end
            join
            acc(1'h1, 20'h0_0140, 8'h01, junk);
            rd(20'h0_0140, 8'h01);
            busy_hold = 1'h1;
            rd({4'h1, lfsr}, mem_fn(lfsr));
            busy_hold = 1'h0;
            vc_conn = 1'h1;
            rd({4'h1, ~lfsr}, mem_fn(~lfsr));
            vc_conn = 1'h0;
        end
        test_done();
    end
endmodule

bind hbra_top hbra_asserts chk_i (.*);
